// ---- rtl/ucr_control_regs.sv ----
// control word registers of the upconverter with their serial control port and decoded controls
// assumes same-clock datapath inputs for tuning words and ramp timer; all pins pass the synchroniser
`timescale 1ns/1ps
module ucr_control_regs
  import ucr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic csPinN,
  input wire logic sclkPin,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic sdoOut,
  output logic sdoOe,
  input wire logic ioUpdateIn,
  output logic ioUpdateOut,
  output logic ioUpdateOe,
  input wire logic externalPowerDownPin,
  input wire logic txEnablePin,
  input wire logic keyingPin,
  input wire logic [2:0] profilePins,
  input wire logic rampTimerAtOne,
  input wire logic [31:0] ftwStored,
  input wire logic [31:0] ftwActive,
  output ucr_ctrl_t ctrl
);

  ucr_state_t state_q;
  ucr_state_t state_d;
  ucr_pins_t pinsRaw;
  ucr_pins_t pinsSync;

  assign pinsRaw = '{csN: csPinN, sclk: sclkPin, sdio: sdioIn, ioUpd: ioUpdateIn, extPd: externalPowerDownPin,
                     txEn: txEnablePin, keying: keyingPin, profile: profilePins};

  ucr_pin_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn(pinsRaw),
    .pinOut(pinsSync)
  );

  function automatic logic [31:0] shiftIn(input logic [31:0] w, input logic b, input logic lsb);
    shiftIn = lsb ? {b, w[31:1]} : {w[30:0], b};
  endfunction : shiftIn

  function automatic logic [7:0] instrOf(input logic [31:0] w, input logic lsb);
    instrOf = lsb ? w[31:24] : w[7:0];
  endfunction : instrOf

  function automatic logic [31:0] readWord(input logic [4:0] a, input ucr_control_function_word_one_t c1, input ucr_control_function_word_two_t c2,
                                           input logic [31:0] ftwS, input logic [31:0] ftwA);
    case (a)
      ADDR_CONTROL_FUNCTION_WORD_ONE: readWord = c1;
      ADDR_CONTROL_FUNCTION_WORD_TWO: readWord = c2;
      ADDR_FTW: readWord = c2.readActiveFtw ? ftwA : ftwS;
      default: readWord = 32'h0000_0000;
    endcase
  endfunction : readWord

  logic sclkRise;
  logic sclkFall;
  logic lsb;
  logic [31:0] newShift;
  logic [7:0] instr;
  logic extCommit;
  logic intCommit;
  logic commit;
  logic extPd;
  logic autoPd;
  logic [2:0] profNext;
  ucr_control_function_word_one_t c1;
  ucr_control_function_word_two_t c2;

  always_comb begin
    state_d = state_q;
    c1 = state_q.control_function_word_one;
    c2 = state_q.control_function_word_two;
    sclkRise = pinsSync.sclk & ~state_q.sclkPrev;
    sclkFall = ~pinsSync.sclk & state_q.sclkPrev;
    lsb = c1.lsbFirst;
    newShift = shiftIn(state_q.shift, pinsSync.sdio, lsb);
    instr = instrOf(newShift, lsb);
    state_d.sclkPrev = pinsSync.sclk;
    state_d.ioUpdPrev = pinsSync.ioUpd;

    // serial control port
    if (pinsSync.csN) begin
      state_d.phase = SP_IDLE;
      state_d.bitCnt = 6'h00;
      state_d.ramWrite = 1'b0;
      state_d.sdioOe = 1'b0;
      state_d.sdoOe = 1'b0;
    end else begin
      case (state_q.phase)
        SP_IDLE: begin
          state_d.phase = SP_INSTR;
          state_d.bitCnt = 6'h00;
        end
        SP_INSTR: begin
          if (sclkRise) begin
            state_d.shift = newShift;
            if (state_q.bitCnt == INSTR_LAST) begin
              state_d.isRead = instr[INSTR_READ_POS];
              state_d.addr = instr[4:0];
              state_d.bitCnt = 6'h00;
              state_d.phase = SP_DATA;
              state_d.rdWord = readWord(instr[4:0], c1, c2, ftwStored, ftwActive);
              state_d.ramWrite = ~instr[INSTR_READ_POS] & (instr[4:0] == ADDR_RAM);
            end else begin
              state_d.bitCnt = state_q.bitCnt + 6'h01;
            end
          end
        end
        SP_DATA: begin
          if (state_q.isRead) begin
            if (sclkFall) begin
              state_d.sdioOut = lsb ? state_q.rdWord[0] : state_q.rdWord[31];
              state_d.sdoOut = state_d.sdioOut;
              state_d.rdWord = lsb ? {1'b0, state_q.rdWord[31:1]} : {state_q.rdWord[30:0], 1'b0};
              state_d.sdioOe = ~c1.sdioInputOnly;
              state_d.sdoOe = c1.sdioInputOnly;
            end
            if (sclkRise) begin
              state_d.bitCnt = state_q.bitCnt + 6'h01;
              if (state_q.bitCnt == WORD_LAST) begin
                state_d.phase = SP_DONE;
              end
            end
          end else if (sclkRise) begin
            state_d.shift = newShift;
            state_d.bitCnt = state_q.bitCnt + 6'h01;
            if (state_q.bitCnt == WORD_LAST) begin
              state_d.bitCnt = 6'h00;
              if (state_q.addr == ADDR_CONTROL_FUNCTION_WORD_ONE) begin
                state_d.cfr1Pend = newShift;
              end
              if (state_q.addr == ADDR_CONTROL_FUNCTION_WORD_TWO) begin
                state_d.cfr2Pend = newShift;
              end
              // ram data streams word after word until chip select rises
              if (state_q.addr != ADDR_RAM) begin
                state_d.phase = SP_DONE;
              end
            end
          end
        end
        SP_DONE: begin
          if (sclkFall) begin
            state_d.sdioOe = 1'b0;
            state_d.sdoOe = 1'b0;
          end
        end
        default: begin
          state_d.phase = SP_IDLE;
        end
      endcase
    end

    // register commit, external pin edge or internal down counter
    extCommit = ~c2.internalCommit & pinsSync.ioUpd & ~state_q.ioUpdPrev;
    intCommit = c2.internalCommit & (state_q.ioCnt == 8'h00);
    if (c2.internalCommit && state_q.ioCnt != 8'h00) begin
      state_d.ioCnt = state_q.ioCnt - 8'h01;
    end else begin
      state_d.ioCnt = IO_UPDATE_RELOAD;
    end
    commit = extCommit | intCommit;
    state_d.ioUpdOut = intCommit;
    state_d.ioUpdOe = c2.internalCommit;
    if (commit) begin
      state_d.control_function_word_one = state_d.cfr1Pend;
      state_d.control_function_word_two = state_d.cfr2Pend;
    end

    // automatic power down after a long idle transmit enable
    if (c1.autoPdEn && !pinsSync.txEn) begin
      if (state_q.idleCnt != AUTO_PD_CYCLES) begin
        state_d.idleCnt = state_q.idleCnt + 8'h01;
      end
    end else begin
      state_d.idleCnt = 8'h00;
    end
    autoPd = c1.autoPdEn & (state_q.idleCnt == AUTO_PD_CYCLES);
    extPd = pinsSync.extPd;

    // profile selection
    state_d.ctrl.profileLoop = |c1.profileCtl;
    if (|c1.profileCtl) begin
      profNext = commit ? state_q.ctrl.profileSel + 3'h1 : state_q.ctrl.profileSel;
    end else begin
      profNext = pinsSync.profile;
    end
    state_d.ctrl.profileSel = profNext;
    state_d.ctrl.profileChange = profNext != state_q.ctrl.profileSel;

    // decoded controls
    state_d.ctrl.ramPowerDown = ~c1.ramEnable & ~state_d.ramWrite;
    state_d.ctrl.ramDrivesIq = c1.ramEnable & c1.ramEval;
    state_d.ctrl.modeQuad = c1.opMode == 2'h0;
    state_d.ctrl.modeSingleTone = c1.opMode == 2'h1;
    state_d.ctrl.modeInterpDac = c1.opMode[1];
    state_d.ctrl.keyingPinUsed = c1.keyEnable & ~c1.keyAuto & c1.keyExtCtl;
    state_d.ctrl.keyingManualOn = c1.keyEnable & ~c1.keyAuto & (~c1.keyExtCtl | pinsSync.keying);
    state_d.ctrl.keyingClockEnable = c1.keyEnable;
    state_d.ctrl.keyingAutoMode = c1.keyEnable & c1.keyAuto;
    state_d.ctrl.invSincClockEnable = c1.invSincEn;
    state_d.ctrl.invSincBypass = ~c1.invSincEn;
    state_d.ctrl.combClear = c1.combClear;
    state_d.ctrl.sineSelect = c1.sineSel;
    state_d.ctrl.phaseLoadZero = commit & c1.autoClrPhase;
    state_d.ctrl.phaseClear = c1.clrPhase;
    state_d.ctrl.rampReload = rampTimerAtOne | (c1.rampReloadOnCommit & (commit | state_d.ctrl.profileChange));
    state_d.ctrl.digitalPd = c1.digitalPd | extPd | autoPd;
    state_d.ctrl.dacDigitalPd = c1.dacPd | extPd | autoPd;
    state_d.ctrl.dacAnalogPd = c1.dacPd | (extPd & c1.extPdFull);
    state_d.ctrl.clockInputPd = c1.clkInPd | (extPd & c1.extPdFull);
    state_d.ctrl.serialPortMode = c2.serialPortMode;
    state_d.ctrl.serialLsbFirst = c2.serialPortMode & c2.serialLsbFirst;
    state_d.ctrl.earlyFrameSync = c2.serialPortMode & c2.earlyFrameSync;
    state_d.ctrl.stAmplitudeEnable = c2.stProfileEn;
    state_d.ctrl.commitPulse = commit;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign sdioOut = state_q.sdioOut;
  assign sdioOe = state_q.sdioOe;
  assign sdoOut = state_q.sdoOut;
  assign sdoOe = state_q.sdoOe;
  assign ioUpdateOut = state_q.ioUpdOut;
  assign ioUpdateOe = state_q.ioUpdOe;
  assign ctrl = state_q.ctrl;

endmodule : ucr_control_regs

// ---- rtl/ucr_pkg.sv ----
// package of the upconverter control register block: addresses, reset words, field layouts, state types
// assumes a single 200 MHz mclk domain and a host that drives the serial control port pins
// Summary of operation
// - ram enable low keeps ram in lowest power unless serial port writes it
// - ram evaluation plus ram enable feeds iq samples from ram, not input port
// - mode 00 quadrature, 01 single tone, 1x interpolating dac
// - keying pin used only in manual keying with external keying bit set
// - inverse sinc off stops its clock and bypasses input to output
// - comb integrator clear bit holds that filter in asynchronous clear
// - nonzero internal profile field ignores profile pins and steps profiles itself
// - sine select bit picks cosine at 0, sine at 1
// - auto clear phase loads zeros into accumulator for one cycle per commit
// - phase clear bit holds phase accumulator in asynchronous clear
// - ramp timer reloads at one; with reload bit also on commit or profile change
// - keying enable stops keying clocks when 0; auto bit picks manual or automatic
// - three bits power down digital logic, dac and clock input sections
// - power down pin drops digital only, or everything when full mode bit set
// - auto power down enters low power after long transmit enable deassertion
// - serial data pin bidirectional at 0, input only with separate output at 1
// - serial port shifts msb first at 0, lsb first at 1
// - serial data port mode takes iq by dsp serial port with its bit order
// - early frame sync bit sets whether frame sync leads first bit by one
// - single tone profile enable allows direct amplitude modulation through profiles
// - internal commit bit makes a down counter commit and turns commit pin output
// - read of tuning word address returns stored word or active word per select bit
package ucr_pkg;

  localparam logic [4:0] ADDR_CONTROL_FUNCTION_WORD_ONE = 5'h00;
  localparam logic [4:0] ADDR_CONTROL_FUNCTION_WORD_TWO = 5'h01;
  localparam logic [4:0] ADDR_FTW = 5'h07;
  localparam logic [4:0] ADDR_RAM = 5'h16;

  localparam logic [31:0] CONTROL_FUNCTION_WORD_ONE_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_FUNCTION_WORD_TWO_RESET = 32'h0040_0820;

  localparam int INSTR_BITS = 8;
  localparam int WORD_BITS = 32;
  localparam int INSTR_READ_POS = 7;
  localparam logic [5:0] INSTR_LAST = 6'(INSTR_BITS - 1);
  localparam logic [5:0] WORD_LAST = 6'(WORD_BITS - 1);

  localparam int CLK_PERIOD_NS = 5;
  // least idle time before automatic power down, rounded up
  localparam int AUTO_PD_NS = 1000;
  localparam int AUTO_PD_CYCLES_I = (AUTO_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // interval of the internal commit counter, rounded down
  localparam int IO_UPDATE_NS = 1000;
  localparam int IO_UPDATE_CYCLES_I = IO_UPDATE_NS / CLK_PERIOD_NS;
  localparam logic [7:0] AUTO_PD_CYCLES = 8'(AUTO_PD_CYCLES_I);
  localparam logic [7:0] IO_UPDATE_RELOAD = 8'(IO_UPDATE_CYCLES_I - 1);

  localparam int SYNC_PINS = 10;
  localparam logic [SYNC_PINS-1:0] PINS_RESET = 10'h200;

  typedef struct packed {
    logic ramEnable;
    logic [1:0] open30;
    logic ramEval;
    logic [1:0] open26;
    logic [1:0] opMode;
    logic keyExtCtl;
    logic invSincEn;
    logic combClear;
    logic [3:0] profileCtl;
    logic sineSel;
    logic [1:0] open14;
    logic autoClrPhase;
    logic open12;
    logic clrPhase;
    logic rampReloadOnCommit;
    logic keyEnable;
    logic keyAuto;
    logic digitalPd;
    logic dacPd;
    logic clkInPd;
    logic open4;
    logic extPdFull;
    logic autoPdEn;
    logic sdioInputOnly;
    logic lsbFirst;
  } ucr_control_function_word_one_t;

  typedef struct packed {
    logic serialPortMode;
    logic serialLsbFirst;
    logic earlyFrameSync;
    logic [3:0] open25;
    logic stProfileEn;
    logic internalCommit;
    logic ioSyncClkEn;
    logic [4:0] open17;
    logic readActiveFtw;
    logic [15:0] lower;
  } ucr_control_function_word_two_t;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic sdio;
    logic ioUpd;
    logic extPd;
    logic txEn;
    logic keying;
    logic [2:0] profile;
  } ucr_pins_t;

  typedef struct packed {
    logic ramPowerDown;
    logic ramDrivesIq;
    logic modeQuad;
    logic modeSingleTone;
    logic modeInterpDac;
    logic keyingPinUsed;
    logic keyingManualOn;
    logic keyingClockEnable;
    logic keyingAutoMode;
    logic invSincClockEnable;
    logic invSincBypass;
    logic combClear;
    logic profileLoop;
    logic [2:0] profileSel;
    logic profileChange;
    logic sineSelect;
    logic phaseLoadZero;
    logic phaseClear;
    logic rampReload;
    logic digitalPd;
    logic dacDigitalPd;
    logic dacAnalogPd;
    logic clockInputPd;
    logic serialPortMode;
    logic serialLsbFirst;
    logic earlyFrameSync;
    logic stAmplitudeEnable;
    logic commitPulse;
  } ucr_ctrl_t;

  localparam ucr_ctrl_t CTRL_RESET = '{ramPowerDown: 1'b1, modeQuad: 1'b1, invSincBypass: 1'b1, default: '0};

  typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA, SP_DONE} ucr_phase_t;

  typedef struct packed {
    ucr_control_function_word_one_t control_function_word_one;
    ucr_control_function_word_two_t control_function_word_two;
    ucr_control_function_word_one_t cfr1Pend;
    ucr_control_function_word_two_t cfr2Pend;
    ucr_phase_t phase;
    logic [5:0] bitCnt;
    logic [31:0] shift;
    logic [31:0] rdWord;
    logic isRead;
    logic [4:0] addr;
    logic ramWrite;
    logic sclkPrev;
    logic ioUpdPrev;
    logic [7:0] ioCnt;
    logic [7:0] idleCnt;
    logic sdioOut;
    logic sdioOe;
    logic sdoOut;
    logic sdoOe;
    logic ioUpdOut;
    logic ioUpdOe;
    ucr_ctrl_t ctrl;
  } ucr_state_t;

  localparam ucr_state_t STATE_RESET = '{control_function_word_one: CONTROL_FUNCTION_WORD_ONE_RESET, control_function_word_two: CONTROL_FUNCTION_WORD_TWO_RESET, cfr1Pend: CONTROL_FUNCTION_WORD_ONE_RESET,
                                         cfr2Pend: CONTROL_FUNCTION_WORD_TWO_RESET, phase: SP_IDLE, ctrl: CTRL_RESET, default: '0};

  typedef struct packed {
    logic [SYNC_PINS-1:0] s1;
    logic [SYNC_PINS-1:0] s2;
    logic [SYNC_PINS-1:0] s3;
    logic [SYNC_PINS-1:0] filt;
  } ucr_sync_t;

  localparam ucr_sync_t SYNC_RESET = '{s1: PINS_RESET, s2: PINS_RESET, s3: PINS_RESET, filt: PINS_RESET};

endpackage : ucr_pkg

// ---- rtl/ucr_pin_sync.sv ----
// three-stage synchroniser with agreement filter for the asynchronous pins
// assumes pins are quasi static relative to a 5 ns mclk
`timescale 1ns/1ps
module ucr_pin_sync
  import ucr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [SYNC_PINS-1:0] pinIn,
  output logic [SYNC_PINS-1:0] pinOut
);

  ucr_sync_t sync_q;
  ucr_sync_t sync_d;

  always_comb begin
    sync_d = sync_q;
    sync_d.s1 = pinIn;
    sync_d.s2 = sync_q.s1;
    sync_d.s3 = sync_q.s2;
    // a change counts once stage two and three agree
    for (int i = 0; i < SYNC_PINS; i++) begin
      if (sync_q.s2[i] == sync_q.s3[i]) begin
        sync_d.filt[i] = sync_q.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= SYNC_RESET;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign pinOut = sync_q.filt;

endmodule : ucr_pin_sync

// ---- sim/ucr_control_regs_chk.sv ----
// checker of the control register block, port-level relations only
// assumes binding onto ucr_control_regs in the mclk domain
`timescale 1ns/1ps
module ucr_control_regs_chk
  import ucr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sdioOe,
  input wire logic sdoOe,
  input wire logic ioUpdateOut,
  input wire logic ioUpdateOe,
  input wire logic rampTimerAtOne,
  input wire ucr_ctrl_t ctrl
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_mode_one_hot: assert property ($onehot({ctrl.modeQuad, ctrl.modeSingleTone, ctrl.modeInterpDac}))
    else $error("mode flags not one-hot");
  a_ram_feeds_iq: assert property (ctrl.ramDrivesIq |-> !ctrl.ramPowerDown)
    else $error("ram feeds iq while powered down");
  a_sinc_bypass: assert property (ctrl.invSincBypass != ctrl.invSincClockEnable)
    else $error("sinc bypass and clock disagree");
  a_keying_pin: assert property (ctrl.keyingPinUsed |-> ctrl.keyingClockEnable && !ctrl.keyingAutoMode)
    else $error("keying pin used outside manual keying");
  a_keying_auto: assert property (ctrl.keyingAutoMode |-> ctrl.keyingClockEnable)
    else $error("auto keying with clocks stopped");
  a_phase_zero_pulse: assert property (ctrl.phaseLoadZero |-> ctrl.commitPulse ##1 !ctrl.phaseLoadZero)
    else $error("phase zero load not a single commit cycle");
  a_commit_out: assert property (ioUpdateOut |-> ioUpdateOe && ctrl.commitPulse)
    else $error("commit pin pulse without internal commit");
  a_commit_gap: assert property (ioUpdateOut |=> !ioUpdateOut [*8])
    else $error("internal commits too close");
  a_oe_exclusive: assert property (!(sdioOe && sdoOe))
    else $error("both serial outputs enabled");
  a_ramp_timer: assert property (rampTimerAtOne |-> ##[1:2] ctrl.rampReload)
    else $error("ramp timer timeout without reload");
  c_commit: cover property (ctrl.commitPulse);
  c_internal: cover property (ioUpdateOut);
  c_sdo_read: cover property (sdoOe);
endmodule : ucr_control_regs_chk

bind ucr_control_regs ucr_control_regs_chk u_chk (.mclk(mclk), .rst_n(rst_n), .sdioOe(sdioOe), .sdoOe(sdoOe),
  .ioUpdateOut(ioUpdateOut), .ioUpdateOe(ioUpdateOe), .rampTimerAtOne(rampTimerAtOne), .ctrl(ctrl));

// ---- sim/ucr_host_model.sv ----
// host model driving the serial control port and the commit pin
// assumes sclk phases of 8 mclk, well above the pin synchroniser delay
`timescale 1ns/1ps
module ucr_host_model (
  input wire logic mclk,
  input wire logic dOut,
  input wire logic dOe,
  input wire logic sdoOut,
  output logic csN,
  output logic sclk,
  output logic sdio,
  output logic ioUpd
);
  logic hOe = 1'h1, hBit = 1'h0, tog = 1'h0, lsb = 1'h0, wire3 = 1'h0;
  initial begin
    csN = 1'h1;
    sclk = 1'h0;
    ioUpd = 1'h0;
  end
  // released line toggles so a stale bit never passes for read data
  always @(posedge mclk) tog <= ~tog;
  assign sdio = dOe ? dOut : (hOe ? hBit : tog);
  task automatic xfer(input logic [7:0] ins, input logic [31:0] d, output logic [31:0] q);
    logic [39:0] w;
    int b;
    w = {ins, d};
    q = 32'h0;
    csN <= 1'h0;
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 40; i++) begin
      b = !lsb ? 39 - i : (i < 8 ? 32 + i : i - 8);
      hBit <= w[b];
      if (i == 8 && ins[7]) hOe <= 1'h0;
      repeat (8) @(posedge mclk);
      if (i >= 8) q[b] = wire3 ? sdoOut : sdio;
      sclk <= 1'h1;
      repeat (8) @(posedge mclk);
      sclk <= 1'h0;
    end
    repeat (8) @(posedge mclk);
    csN <= 1'h1;
    hOe <= 1'h1;
    repeat (8) @(posedge mclk);
  endtask : xfer
  task automatic upd();
    ioUpd <= 1'h1;
    repeat (8) @(posedge mclk);
    ioUpd <= 1'h0;
    repeat (8) @(posedge mclk);
  endtask : upd
endmodule : ucr_host_model

// ---- sim/tb_top.sv ----
// self-checking bench of the control register block
// assumes the host model on the serial pins and the commit pin; the bench drives the remaining pins
`timescale 1ns/1ps
module tb_top;
  import ucr_pkg::*;
  logic mclk = 1'h0, rst_n = 1'h0, extPd = 1'h0, txEn = 1'h1, keying = 1'h0, rampAt1 = 1'h0;
  logic csN, sclk, sdio, ioUpd, ioWire, sdioOut, sdioOe, sdoOut, sdoOe, ioOut, ioOe;
  logic [2:0] prof = 3'h0, s;
  logic [31:0] ftwS = 32'h1234_5678, ftwA = 32'h9ABC_DEF0, r;
  ucr_ctrl_t ctrl;
  int error_cnt = 0, tests_run = 0, cyc = 0, n, p;
  assign ioWire = ioOe ? ioOut : ioUpd;
  ucr_control_regs dut (.mclk(mclk), .rst_n(rst_n), .csPinN(csN), .sclkPin(sclk), .sdioIn(sdio),
    .sdioOut(sdioOut), .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .ioUpdateIn(ioWire),
    .ioUpdateOut(ioOut), .ioUpdateOe(ioOe), .externalPowerDownPin(extPd), .txEnablePin(txEn),
    .keyingPin(keying), .profilePins(prof), .rampTimerAtOne(rampAt1), .ftwStored(ftwS),
    .ftwActive(ftwA), .ctrl(ctrl));
  ucr_host_model host (.mclk(mclk), .dOut(sdioOut), .dOe(sdioOe), .sdoOut(sdoOut), .csN(csN),
    .sclk(sclk), .sdio(sdio), .ioUpd(ioUpd));
  initial forever #2.5 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic waitc(input int k);
    repeat (k) @(posedge mclk);
  endtask : waitc
  task automatic rd(input logic [4:0] a);
    host.xfer({3'h4, a}, 32'h0, r);
  endtask : rd
  task automatic cfg(input logic [4:0] a, input logic [31:0] d);
    host.xfer({3'h0, a}, d, r);
    host.upd();
    waitc(12);
  endtask : cfg
  task automatic cnt();
    n = 0;
    p = 0;
    fork
      host.upd();
      repeat (30) begin
        @(posedge mclk);
        n += ctrl.phaseLoadZero;
        p += ctrl.rampReload;
      end
    join
  endtask : cnt
  task automatic t_reset();
    chk(ctrl, CTRL_RESET);
    chk({sdioOe, sdoOe, ioOe}, 3'h0);
    rd(ADDR_CONTROL_FUNCTION_WORD_ONE);
    chk(r, CONTROL_FUNCTION_WORD_ONE_RESET);
    rd(ADDR_CONTROL_FUNCTION_WORD_TWO);
    chk(r, CONTROL_FUNCTION_WORD_TWO_RESET);
    rd(5'h05);
    chk(r, 32'h0);
    rd(ADDR_FTW);
    chk(r, ftwS);
  endtask : t_reset
  task automatic t_modes();
    host.xfer(8'h00, 32'h0101_0000, r);
    chk(ctrl.modeSingleTone, 1'h0);
    host.upd();
    waitc(12);
    chk({ctrl.modeSingleTone, ctrl.sineSelect}, 2'h3);
    for (int m = 0; m < 4; m++) begin
      cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, {6'h0, 2'(m), 24'h0});
      chk({ctrl.modeInterpDac, ctrl.modeSingleTone, ctrl.modeQuad}, m[1] ? 3'h4 : (m[0] ? 3'h2 : 3'h1));
    end
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h1000_0000);
    chk({ctrl.ramPowerDown, ctrl.ramDrivesIq}, 2'h2);
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h9000_0000);
    chk({ctrl.ramPowerDown, ctrl.ramDrivesIq}, 2'h1);
  endtask : t_modes
  task automatic t_phase();
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0060_2C00);
    chk({ctrl.invSincClockEnable, ctrl.invSincBypass, ctrl.combClear, ctrl.phaseClear}, 4'hB);
    cnt();
    chk(n, 32'h1);
    chk(p, 32'h1);
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0);
    cnt();
    chk(n + p, 32'h0);
    p = 0;
    rampAt1 <= 1'h1;
    @(posedge mclk);
    rampAt1 <= 1'h0;
    repeat (4) begin
      @(posedge mclk);
      p += ctrl.rampReload;
    end
    chk(p, 32'h1);
  endtask : t_phase
  task automatic t_key();
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0080_0200);
    chk({ctrl.keyingPinUsed, ctrl.keyingClockEnable, ctrl.keyingAutoMode}, 3'h6);
    keying <= 1'h1;
    waitc(10);
    chk(ctrl.keyingManualOn, 1'h1);
    keying <= 1'h0;
    waitc(10);
    chk(ctrl.keyingManualOn, 1'h0);
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0080_0300);
    chk({ctrl.keyingPinUsed, ctrl.keyingClockEnable, ctrl.keyingAutoMode}, 3'h3);
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0080_0000);
    chk({ctrl.keyingPinUsed, ctrl.keyingClockEnable, ctrl.keyingAutoMode}, 3'h0);
  endtask : t_key
  task automatic t_power();
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0000_00E0);
    chk({ctrl.digitalPd, ctrl.dacAnalogPd, ctrl.clockInputPd}, 3'h7);
    extPd <= 1'h1;
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0);
    chk({ctrl.digitalPd, ctrl.dacDigitalPd, ctrl.dacAnalogPd, ctrl.clockInputPd}, 4'hC);
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h8);
    chk({ctrl.digitalPd, ctrl.dacDigitalPd, ctrl.dacAnalogPd, ctrl.clockInputPd}, 4'hF);
    extPd <= 1'h0;
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h4);
    txEn <= 1'h0;
    waitc(150);
    chk(ctrl.digitalPd, 1'h0);
    waitc(70);
    chk(ctrl.digitalPd, 1'h1);
    txEn <= 1'h1;
    waitc(10);
    chk(ctrl.digitalPd, 1'h0);
  endtask : t_power
  task automatic t_format();
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0000_0003);
    host.lsb = 1'h1;
    host.wire3 = 1'h1;
    rd(ADDR_CONTROL_FUNCTION_WORD_ONE);
    chk(r, 32'h3);
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0);
    host.lsb = 1'h0;
    host.wire3 = 1'h0;
    rd(ADDR_CONTROL_FUNCTION_WORD_ONE);
    chk(r, 32'h0);
  endtask : t_format
  task automatic t_control_function_word_two();
    cfg(ADDR_CONTROL_FUNCTION_WORD_TWO, 32'hE141_0820);
    chk({ctrl.serialPortMode, ctrl.serialLsbFirst, ctrl.earlyFrameSync}, 3'h7);
    rd(ADDR_FTW);
    chk(r, ftwA);
    cfg(ADDR_CONTROL_FUNCTION_WORD_TWO, 32'h6040_0820);
    chk({ctrl.serialPortMode, ctrl.serialLsbFirst, ctrl.earlyFrameSync, ctrl.stAmplitudeEnable}, 4'h0);
  endtask : t_control_function_word_two
  task automatic t_loop();
    prof <= 3'h5;
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0);
    chk(ctrl.profileSel, 3'h5);
    cfg(ADDR_CONTROL_FUNCTION_WORD_ONE, 32'h0002_0000);
    s = ctrl.profileSel;
    host.upd();
    waitc(12);
    chk({ctrl.profileLoop, ctrl.profileSel}, {1'h1, s + 3'h1});
  endtask : t_loop
  task automatic t_internal();
    cfg(ADDR_CONTROL_FUNCTION_WORD_TWO, 32'h00C0_0820);
    chk(ioOe, 1'h1);
    n = 0;
    p = 0;
    fork
      host.upd();
      repeat (400) begin
        @(posedge mclk);
        n += ioOut;
        p += ctrl.commitPulse;
      end
    join
    chk(n, 32'h2);
    chk(p, 32'h2);
    host.xfer(8'h01, CONTROL_FUNCTION_WORD_TWO_RESET, r);
    waitc(220);
    chk(ioOe, 1'h0);
  endtask : t_internal
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    waitc(10);
    rst_n <= 1'h1;
    waitc(6);
    t_reset();
    t_modes();
    t_phase();
    t_key();
    t_power();
    t_format();
    t_control_function_word_two();
    t_loop();
    t_internal();
    close_out();
  end
endmodule : tb_top
